// file: core/itew_top.sv
// Purpose: Idle countdown timer with system and break event logic
// Assumes: Inputs synchronous to i_clk; config bus is a simple strobe port
// Notes: Granularity field lives in a small control register of this block
// What this block does
// - Event enable register clears to zero
// - Enabled system event reloads idle timer
// - Enabled break event releases stop clock
// - Bit 31 makes mgmt interrupt both events
// - Bit 30 makes any interrupt break
// - Bit 29 makes NMI both events
// - Bit 28 external controller break only
// - IRQ bits 15:3,1:0 both events; others reserved
// - Timer register holds count minus one
// - System event loads X plus one
// - At zero: interrupt and reload X+1
// - Expiry issues a special cycle pulse
// - Counts only when enabled, tick per field
// - Timer read returns last written value
// - Status bits for enabled IRQs 1,3,4,8,12 and expiry
// - Field selects minute, off, clock, millisecond
// - Hardware set beats software clear
// - Restart next clock; set expired status
`timescale 1ns/100ps
module itew_top #(
    parameter longint TICK_MS_CYC = itew_pkg::ITEW_TICK_MS_CYC,
    parameter longint TICK_MIN_CYC = itew_pkg::ITEW_TICK_MIN_CYC
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire itew_pkg::itew_cfg_req_s i_cfg,
    input wire itew_pkg::itew_events_s i_events,
    input wire logic i_stop_clock_req,
    output logic [31:0] o_cfg_rdata,
    output logic o_cfg_ack,
    output logic o_stop_clock_n,
    output logic o_mgmt_interrupt_n,
    output logic o_mgmt_special_cycle
);
    import itew_pkg::*;

    logic [31:0] event_enable_reg;
    logic [7:0] idle_timer_value_reg;
    logic [15:0] interrupt_request_status_reg;
    logic [15:0] status_next;
    logic [31:0] status_merged;
    itew_gran_e idle_timer_granularity_reg;
    logic [8:0] counter_reg;
    itew_events_s events_prev_reg;
    logic tick;
    logic [15:0] irq_rise;
    logic intr_rise;
    logic nmi_rise;
    logic ext_rise;
    logic expire;
    logic system_event;
    logic break_event;
    logic [15:0] status_set;
    logic wr_event_en;
    logic wr_timer;
    logic wr_status;
    logic wr_ctrl;

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    itew_tick_gen #(
        .TICK_MS_CYC(TICK_MS_CYC),
        .TICK_MIN_CYC(TICK_MIN_CYC)
    ) u_tick (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_gran(idle_timer_granularity_reg),
        .o_tick(tick)
    );

    // Address decode
    always_comb begin
        wr_event_en = 1'b0;
        wr_timer = 1'b0;
        wr_status = 1'b0;
        wr_ctrl = 1'b0;
        if (i_cfg.addr == ITEW_OFS_EVENT_EN) begin
            wr_event_en = i_cfg.wr;
        end else if (i_cfg.addr == ITEW_OFS_TIMER_VAL) begin
            wr_timer = i_cfg.wr && i_cfg.be[0];
        end else if (i_cfg.addr == ITEW_OFS_STATUS) begin
            wr_status = i_cfg.wr;
        end else if (i_cfg.addr == ITEW_OFS_CONTROL) begin
            wr_ctrl = i_cfg.wr && i_cfg.be[0];
        end
    end

    // Rising-edge detection of event inputs
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            events_prev_reg <= '0;
        end else begin
            events_prev_reg <= i_events;
        end
    end

    always_comb begin
        irq_rise = i_events.irq & ~events_prev_reg.irq;
        intr_rise = i_events.intr & ~events_prev_reg.intr;
        nmi_rise = i_events.nmi & ~events_prev_reg.nmi;
        ext_rise = i_events.ext_intc & ~events_prev_reg.ext_intc;
        expire = tick && counter_reg == 9'h0;
        // IRQ enables sit in bits 15:0, reserved bit 2 masked at write
        system_event = |(irq_rise & event_enable_reg[15:0])
            | (nmi_rise & event_enable_reg[ITEW_BIT_NMI])
            | (expire & event_enable_reg[ITEW_BIT_MGMT]);
        break_event = system_event
            | (intr_rise & event_enable_reg[ITEW_BIT_GLOBAL_INTR])
            | (ext_rise & event_enable_reg[ITEW_BIT_EXT_INTC]);
        status_set = 16'h0;
        status_set[ITEW_BIT_EXPIRED] = expire;
        // Low status bits mirror enabled IRQs 1,3,4,8,12
        status_set[0] = irq_rise[1] & event_enable_reg[1];
        status_set[1] = irq_rise[3] & event_enable_reg[3];
        status_set[2] = irq_rise[4] & event_enable_reg[4];
        status_set[3] = irq_rise[8] & event_enable_reg[8];
        status_set[4] = irq_rise[12] & event_enable_reg[12];
        status_merged = merge_bytes({16'h0, interrupt_request_status_reg},
                                    i_cfg.wdata, i_cfg.be);
        status_next = interrupt_request_status_reg;
        if (wr_status) begin
            status_next = status_merged[15:0] & ITEW_STATUS_MASK;
        end
        status_next = status_next | status_set;
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            event_enable_reg <= ITEW_EVENT_EN_RESET;
        end else if (wr_event_en) begin
            event_enable_reg <= merge_bytes(event_enable_reg, i_cfg.wdata, i_cfg.be)
                                & ITEW_EVENT_EN_MASK;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            idle_timer_value_reg <= ITEW_TIMER_VAL_RESET;
        end else if (wr_timer) begin
            idle_timer_value_reg <= i_cfg.wdata[7:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            idle_timer_granularity_reg <= itew_gran_e'(ITEW_GRAN_RESET);
        end else if (wr_ctrl) begin
            idle_timer_granularity_reg <=
                itew_gran_e'(i_cfg.wdata[ITEW_CTRL_GRAN_LSB +: 2]);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            interrupt_request_status_reg <= ITEW_STATUS_RESET;
        end else begin
            interrupt_request_status_reg <= status_next;
        end
    end

    // Idle countdown; holds X+1 so X gives X+2 ticks between expiries
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            counter_reg <= {1'b0, ITEW_TIMER_VAL_RESET} + 9'h1;
        end else if (wr_timer) begin
            counter_reg <= {1'b0, i_cfg.wdata[7:0]} + 9'h1;
        end else if (system_event || expire) begin
            counter_reg <= {1'b0, idle_timer_value_reg} + 9'h1;
        end else if (tick) begin
            counter_reg <= counter_reg - 9'h1;
        end
    end

    // Management interrupt from any status bit; special cycle on expiry
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_mgmt_interrupt_n <= 1'b1;
            o_mgmt_special_cycle <= 1'b0;
        end else begin
            o_mgmt_interrupt_n <= ~(|status_next);
            o_mgmt_special_cycle <= expire;
        end
    end

    // Stop clock: asserted on request, released by a break event
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_stop_clock_n <= 1'b1;
        end else if (break_event) begin
            o_stop_clock_n <= 1'b1;
        end else if (i_stop_clock_req) begin
            o_stop_clock_n <= 1'b0;
        end
    end

    // Register read, one cycle latency
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_cfg_rdata <= 32'h0;
            o_cfg_ack <= 1'b0;
        end else begin
            o_cfg_ack <= i_cfg.rd || i_cfg.wr;
            o_cfg_rdata <= 32'h0;
            if (i_cfg.rd) begin
                if (i_cfg.addr == ITEW_OFS_EVENT_EN) begin
                    o_cfg_rdata <= event_enable_reg;
                end else if (i_cfg.addr == ITEW_OFS_TIMER_VAL) begin
                    o_cfg_rdata <= {24'h0, idle_timer_value_reg};
                end else if (i_cfg.addr == ITEW_OFS_STATUS) begin
                    o_cfg_rdata <= {16'h0, interrupt_request_status_reg};
                end else if (i_cfg.addr == ITEW_OFS_CONTROL) begin
                    o_cfg_rdata <= {27'h0, idle_timer_granularity_reg, 3'h0};
                end
            end
        end
    end
endmodule

// file: core/itew_pkg.sv
// Purpose: Shared constants and types for the idle timer and event wakeup block
// Assumes: 100 MHz clock; config space reached as 32-bit accesses with byte enables
// Notes: Offsets are configuration-space byte addresses
package itew_pkg;
    localparam logic [7:0] ITEW_OFS_EVENT_EN = 8'ha4;
    localparam logic [7:0] ITEW_OFS_TIMER_VAL = 8'ha8;
    localparam logic [7:0] ITEW_OFS_STATUS = 8'haa;
    localparam logic [7:0] ITEW_OFS_CONTROL = 8'ha0;
    localparam logic [31:0] ITEW_EVENT_EN_RESET = 32'h00000000;
    localparam logic [31:0] ITEW_EVENT_EN_MASK = 32'hf000fffb;
    localparam logic [7:0] ITEW_TIMER_VAL_RESET = 8'h0f;
    localparam logic [15:0] ITEW_STATUS_RESET = 16'h0000;
    localparam logic [15:0] ITEW_STATUS_MASK = 16'h003f;
    localparam logic [1:0] ITEW_GRAN_RESET = 2'b01;
    localparam int ITEW_BIT_MGMT = 31;
    localparam int ITEW_BIT_GLOBAL_INTR = 30;
    localparam int ITEW_BIT_NMI = 29;
    localparam int ITEW_BIT_EXT_INTC = 28;
    localparam int ITEW_BIT_EXPIRED = 5;
    localparam int ITEW_CTRL_GRAN_LSB = 3;
    localparam int ITEW_CLK_MHZ = 100;
    localparam int ITEW_TICK_MS_US = 1000;
    localparam int ITEW_TICK_MS_CYC = ITEW_TICK_MS_US * ITEW_CLK_MHZ;
    localparam int ITEW_TICK_MIN_S = 60;
    localparam longint ITEW_TICK_MIN_CYC = 64'd60 * 64'd1000000 * ITEW_CLK_MHZ;
    typedef enum logic [1:0] {
        ITEW_GRAN_MINUTE = 2'b00,
        ITEW_GRAN_OFF = 2'b01,
        ITEW_GRAN_CLOCK = 2'b10,
        ITEW_GRAN_MSEC = 2'b11
    } itew_gran_e;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } itew_cfg_req_s;
    typedef struct packed {
        logic [15:0] irq;
        logic intr;
        logic nmi;
        logic ext_intc;
    } itew_events_s;
endpackage

// file: core/itew_tick_gen.sv
// Purpose: Tick generator for idle timer granularity
// Assumes: Granularity field held stable while running
// Notes: Minute and millisecond counts are parameters for shortened runs
`timescale 1ns/100ps
module itew_tick_gen #(
    parameter longint TICK_MS_CYC = 100000,
    parameter longint TICK_MIN_CYC = 64'd6000000000
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire itew_pkg::itew_gran_e i_gran,
    output logic o_tick
);
    import itew_pkg::*;
    logic [39:0] count_reg;
    logic [39:0] limit;

    always_comb begin
        limit = 40'h1;
        if (i_gran == ITEW_GRAN_MINUTE) begin
            limit = TICK_MIN_CYC[39:0];
        end else if (i_gran == ITEW_GRAN_MSEC) begin
            limit = TICK_MS_CYC[39:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset || i_gran == ITEW_GRAN_OFF) begin
            count_reg <= 40'h0;
            o_tick <= 1'b0;
        end else if (count_reg + 40'h1 >= limit) begin
            count_reg <= 40'h0;
            o_tick <= 1'b1;
        end else begin
            count_reg <= count_reg + 40'h1;
            o_tick <= 1'b0;
        end
    end
endmodule

// file: dv/itew_host_model.sv
// Purpose: Host side model counting special cycles
// Assumes: One-cycle special cycle pulses
// Notes: Gap is spacing of the last two pulses
`timescale 1ns/100ps
module itew_host_model (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_special_cycle,
    output int o_count,
    output int o_gap
);
    int since;
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_count <= 0;
            o_gap <= 0;
            since <= 0;
        end else if (i_special_cycle) begin
            o_count <= o_count + 1;
            o_gap <= since + 1;
            since <= 0;
        end else begin
            since <= since + 1;
        end
    end
endmodule

// file: dv/itew_top_asserts.sv
// Purpose: Port checker for itew_top
// Assumes: One clock domain
// Notes: Bound at the foot
`timescale 1ns/100ps
module itew_top_asserts #(
    parameter longint TICK_MS_CYC = 4,
    parameter longint TICK_MIN_CYC = 8
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire itew_pkg::itew_cfg_req_s i_cfg,
    input wire itew_pkg::itew_events_s i_events,
    input wire logic i_stop_clock_req,
    input wire logic [31:0] o_cfg_rdata,
    input wire logic o_cfg_ack,
    input wire logic o_stop_clock_n,
    input wire logic o_mgmt_interrupt_n,
    input wire logic o_mgmt_special_cycle
);
    import itew_pkg::*;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    sequence s_rd(logic [7:0] a);
        i_cfg.rd && i_cfg.addr == a ##1 o_cfg_ack;
    endsequence
    a_enable_rsvd: assert property (s_rd(ITEW_OFS_EVENT_EN) |->
        (o_cfg_rdata & ~ITEW_EVENT_EN_MASK) == 0) else $error("enable rsvd set");
    a_status_width: assert property (s_rd(ITEW_OFS_STATUS) |->
        o_cfg_rdata[31:6] == 0) else $error("status rsvd set");
    a_timer_width: assert property (s_rd(ITEW_OFS_TIMER_VAL) |->
        o_cfg_rdata[31:8] == 0) else $error("timer upper set");
    a_ack_follows: assert property ((i_cfg.rd || i_cfg.wr) |=> o_cfg_ack)
        else $error("ack missing");
    a_ack_cause: assert property (!(i_cfg.rd || i_cfg.wr) |=>
        !o_cfg_ack && o_cfg_rdata == 0) else $error("stray ack");
    a_expiry_pulse: assert property (o_mgmt_special_cycle |=> !o_mgmt_special_cycle)
        else $error("long pulse");
    a_expiry_int: assert property (o_mgmt_special_cycle |-> !o_mgmt_interrupt_n)
        else $error("no interrupt");
    a_int_holds: assert property ((!o_mgmt_interrupt_n && !i_cfg.wr) [*2] |=>
        !o_mgmt_interrupt_n) else $error("interrupt dropped");
    a_reset_idle: assert property ($fell(i_reset) |-> o_stop_clock_n &&
        o_mgmt_interrupt_n && !o_mgmt_special_cycle) else $error("reset outputs");
endmodule
bind itew_top itew_top_asserts #(.TICK_MS_CYC(TICK_MS_CYC), .TICK_MIN_CYC(TICK_MIN_CYC)) u_chk (
    .i_clk(i_clk), .i_reset(i_reset), .i_cfg(i_cfg), .i_events(i_events),
    .i_stop_clock_req(i_stop_clock_req), .o_cfg_rdata(o_cfg_rdata), .o_cfg_ack(o_cfg_ack),
    .o_stop_clock_n(o_stop_clock_n), .o_mgmt_interrupt_n(o_mgmt_interrupt_n),
    .o_mgmt_special_cycle(o_mgmt_special_cycle));

// file: dv/itew_top_tb.sv
// Purpose: Self-checking bench for itew_top
// Assumes: Shortened tick counts
// Notes: Inputs change 1 ns after the rising edge
`timescale 1ns/100ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_mismatch++; \
    $display("mismatch %0t got %h exp %h", $time, (a), (e)); end end
module itew_top_tb;
    import itew_pkg::*;
    localparam longint T_MS = 4;
    localparam longint T_MIN = 8;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    itew_cfg_req_s cfg = '0;
    itew_events_s ev = '0;
    logic stop_req = 1'b0;
    logic [31:0] rdata;
    logic ack, stop_n, int_n, spec;
    int n_mismatch = 0;
    int total_checks = 0;
    int cnt, gap, c0;
    bit seen;
    int tick[3] = '{1, int'(T_MS), int'(T_MIN)};
    logic [1:0] gran[3] = '{2'b10, 2'b11, 2'b00};
    logic [31:0] en[5] = '{32'h2, 32'h40000000, 32'h20000000, 32'h10000000, 32'h0};
    int src[5] = '{4, 2, 1, 0, 8};
    itew_top #(.TICK_MS_CYC(T_MS), .TICK_MIN_CYC(T_MIN)) dut (.i_clk(i_clk),
        .i_reset(i_reset), .i_cfg(cfg), .i_events(ev), .i_stop_clock_req(stop_req),
        .o_cfg_rdata(rdata), .o_cfg_ack(ack), .o_stop_clock_n(stop_n),
        .o_mgmt_interrupt_n(int_n), .o_mgmt_special_cycle(spec));
    itew_host_model host (.i_clk(i_clk), .i_reset(i_reset), .i_special_cycle(spec),
        .o_count(cnt), .o_gap(gap));
    initial begin
        forever #5 i_clk = ~i_clk;
    end
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        #1 cfg = '{wr: w, rd: !w, addr: a, be: 4'hf, wdata: d};
        @(posedge i_clk);
        #1 cfg.wr = 1'b0;
        cfg.rd = 1'b0;
        `CHK(ack, 1'b1)
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        `CHK(rdata, e)
    endtask
    task automatic run(input logic [1:0] g, input logic [7:0] x);
        acc(1'b1, ITEW_OFS_CONTROL, 32'h08);
        acc(1'b1, ITEW_OFS_TIMER_VAL, {24'h0, x});
        acc(1'b1, ITEW_OFS_STATUS, 32'h0);
        acc(1'b1, ITEW_OFS_CONTROL, {27'h0, g, 3'h0});
    endtask
    task automatic pulse(input int b, input int n);
        repeat (n) begin
            ev[b] = 1'b1;
            repeat (2) @(posedge i_clk);
            #1 ev[b] = 1'b0;
            repeat (2) @(posedge i_clk);
            #1;
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #100us;
        n_mismatch++;
        test_done();
    end
    initial begin
        repeat (2) @(posedge i_clk);
        #1 i_reset = 1'b0;
        rd(ITEW_OFS_EVENT_EN, 32'h0);
        rd(ITEW_OFS_TIMER_VAL, 32'h0f);
        rd(ITEW_OFS_STATUS, 32'h0);
        rd(ITEW_OFS_CONTROL, 32'h08);
        rd(8'h10, 32'h0);
        acc(1'b1, ITEW_OFS_EVENT_EN, 32'hffffffff);
        rd(ITEW_OFS_EVENT_EN, 32'hf000fffb);
        acc(1'b1, ITEW_OFS_EVENT_EN, 32'h0);
        for (int i = 0; i < 3; i++) begin
            run(gran[i], 8'h02);
            c0 = cnt;
            for (int j = 0; j < 300 && cnt < c0 + 2; j++) @(posedge i_clk);
            #1;
            `CHK(gap, 4 * tick[i])
            `CHK(int_n, 1'b0)
            rd(ITEW_OFS_STATUS, 32'h20);
        end
        rd(ITEW_OFS_TIMER_VAL, 32'h02);
        run(2'b01, 8'h02);
        c0 = cnt;
        repeat (40) @(posedge i_clk);
        #1;
        `CHK(cnt, c0)
        acc(1'b1, ITEW_OFS_EVENT_EN, 32'h2);
        run(2'b10, 8'h10);
        c0 = cnt;
        pulse(4, 10);
        `CHK(cnt, c0)
        rd(ITEW_OFS_STATUS, 32'h1);
        acc(1'b1, ITEW_OFS_EVENT_EN, 32'h10000000);
        run(2'b10, 8'h05);
        c0 = cnt;
        pulse(0, 10);
        `CHK(cnt > c0, 1'b1)
        acc(1'b1, ITEW_OFS_CONTROL, 32'h08);
        for (int i = 0; i < 5; i++) begin
            acc(1'b1, ITEW_OFS_EVENT_EN, en[i]);
            stop_req = 1'b1;
            repeat (3) @(posedge i_clk);
            #1;
            `CHK(stop_n, 1'b0)
            ev[src[i]] = 1'b1;
            seen = 1'b0;
            repeat (4) begin
                @(posedge i_clk);
                #1 if (stop_n === 1'b1) seen = 1'b1;
            end
            `CHK(seen, i < 4)
            stop_req = 1'b0;
            ev[src[i]] = 1'b0;
            repeat (3) @(posedge i_clk);
        end
        acc(1'b1, ITEW_OFS_EVENT_EN, 32'h80000000);
        `CHK(stop_n, 1'b0)
        run(2'b10, 8'h00);
        repeat (4) @(posedge i_clk);
        #1;
        `CHK(stop_n, 1'b1)
        test_done();
    end
endmodule
